// file: core/ddcp_pkg.sv
package ddcp_pkg;
    localparam int SAMPLE_W    = 14;
    localparam int CHAN_W      = 16;
    localparam int NUM_CHAN    = 4;
    localparam int ADDR_W      = 5;
    localparam int CDATA_W     = 8;
    localparam int PDATA_W     = 24;
    localparam int LOC_W       = 7;
    localparam int NUM_LOC     = 128;
    // Page register location in each addressing scheme
    localparam logic [4:0] PAGE_ADDR5  = 5'h1F;
    localparam logic [3:0] PAGE_ADDR4  = 4'hF;
    // Top quarter of the location space is the output page
    localparam logic [1:0] OUT_PAGE_SEL = 2'h3;
    localparam logic [7:0]  PAGE_RESET  = 8'h00;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [23:0] PDATA_IDLE  = 24'hFF_FFFF;
    // Field positions inside the 56-bit concatenated input pin vector
    localparam int PORT16_STRIDE = 16;
    localparam int DIFF_STRIDE   = 28;
    localparam int EXP_STRIDE    = 15;
    localparam int MANT_W        = 12;
    localparam int EXP_W         = 3;
    localparam int AB_SEL_BIT    = 45;

    typedef enum logic [2:0] {
        FMT_QUAD14   = 3'b000,
        FMT_TRIPLE16 = 3'b001,
        FMT_DIFF14   = 3'b010,
        FMT_EXP      = 3'b011,
        FMT_EXP_AB   = 3'b100
    } ddcp_fmt_e;
endpackage

// file: core/ddcp_sample_reg.sv
`timescale 1ns/1ps
module ddcp_sample_reg #(
    parameter int W = 14
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] q_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_reg <= '0;
        end else begin
            q_reg <= d;
        end
    end

    assign q = q_reg;
endmodule

// file: core/ddcp_top.sv
`timescale 1ns/1ps
module ddcp_top
    import ddcp_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ce_n,
    input  wire logic                rd_n,
    input  wire logic                wr_n,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [CDATA_W-1:0]  cdata_in,
    output logic      [CDATA_W-1:0]  cdata_out,
    output logic                     cdata_oe,
    input  wire logic                addr4_mode,
    input  wire logic                wide_mode,
    input  wire logic [PDATA_W-1:0]  out_word,
    output logic      [PDATA_W-1:0]  pdata_out,
    output logic                     pdata_oe,
    input  wire logic [2:0]          input_format,
    input  wire logic [SAMPLE_W-1:0] sample_port_a,
    input  wire logic [SAMPLE_W-1:0] sample_port_b,
    input  wire logic [SAMPLE_W-1:0] sample_port_c,
    input  wire logic [SAMPLE_W-1:0] sample_port_d,
    input  wire logic                sample_valid_n,
    output logic      [CHAN_W-1:0]   chan_word_0,
    output logic      [CHAN_W-1:0]   chan_word_1,
    output logic      [CHAN_W-1:0]   chan_word_2,
    output logic      [CHAN_W-1:0]   chan_word_3,
    output logic                     chan_ab_sel,
    output logic                     chan_strobe,
    output logic      [CDATA_W-1:0]  page_out
);
    typedef struct packed {
        logic [NUM_LOC-1:0][CDATA_W-1:0] mem;
        logic [CDATA_W-1:0]              page;
        logic                            wr_n_d;
        logic [CDATA_W-1:0]              cdata;
        logic                            cdata_oe;
        logic [PDATA_W-1:0]              pdata;
        logic                            pdata_oe;
        logic                            valid_n_d;
        logic [NUM_CHAN-1:0][CHAN_W-1:0] chan;
        logic                            ab_sel;
        logic                            strobe;
    } ddcp_state_s;

    ddcp_state_s st_reg;
    ddcp_state_s st_next;

    logic [NUM_CHAN-1:0][SAMPLE_W-1:0] pin_d;
    logic [NUM_CHAN-1:0][SAMPLE_W-1:0] pin_q;
    logic [NUM_CHAN*SAMPLE_W-1:0]      pins;

    assign pin_d[0] = sample_port_a;
    assign pin_d[1] = sample_port_b;
    assign pin_d[2] = sample_port_c;
    assign pin_d[3] = sample_port_d;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_cap
            ddcp_sample_reg #(.W(SAMPLE_W)) u_cap (
                .clk (clk),
                .rst (rst),
                .d   (pin_d[gi]),
                .q   (pin_q[gi])
            );
        end
    endgenerate

    assign pins = {pin_q[3], pin_q[2], pin_q[1], pin_q[0]};

    logic [LOC_W-1:0]   loc;
    logic               is_page;
    logic               is_out_page;
    logic               access;
    logic               rd_act;
    logic               wr_rise;
    logic [CDATA_W-1:0] rd_val;
    ddcp_fmt_e          fmt;

    always_comb begin
        access = !ce_n;
        if (addr4_mode) begin
            loc     = {st_reg.page[2:0], addr[3:0]};
            is_page = (addr[3:0] == PAGE_ADDR4);
        end else begin
            loc     = {st_reg.page[1:0], addr};
            is_page = (addr == PAGE_ADDR5);
        end
        is_out_page = (loc[LOC_W-1 -: 2] == OUT_PAGE_SEL);
        rd_act  = access && !rd_n && wr_n;
        wr_rise = access && !st_reg.wr_n_d && wr_n;
        rd_val  = is_page ? st_reg.page : st_reg.mem[loc];
        fmt     = ddcp_fmt_e'(input_format);
    end

    always_comb begin
        st_next = st_reg;
        st_next.wr_n_d    = wr_n;
        st_next.valid_n_d = sample_valid_n;
        st_next.strobe    = 1'b0;

        if (wr_rise) begin
            if (is_page) begin
                st_next.page = cdata_in;
            end else begin
                st_next.mem[loc] = cdata_in;
            end
        end

        st_next.cdata_oe = rd_act;
        st_next.cdata    = rd_act ? rd_val : '0;
        st_next.pdata_oe = rd_act && wide_mode;
        if (rd_act && wide_mode) begin
            st_next.pdata = is_out_page ? out_word : PDATA_IDLE;
        end else begin
            st_next.pdata = '0;
        end

        if (!st_reg.valid_n_d) begin
            st_next.strobe = 1'b1;
            st_next.ab_sel = 1'b0;
            case (fmt)
                FMT_QUAD14: begin
                    for (int k = 0; k < NUM_CHAN; k++) begin
                        st_next.chan[k] = {{(CHAN_W-SAMPLE_W){pin_q[k][SAMPLE_W-1]}},
                                           pin_q[k]};
                    end
                end
                FMT_TRIPLE16: begin
                    for (int k = 0; k < 3; k++) begin
                        st_next.chan[k] = pins[k*PORT16_STRIDE +: CHAN_W];
                    end
                    st_next.chan[3] = '0;
                end
                FMT_DIFF14: begin
                    for (int k = 0; k < 2; k++) begin
                        st_next.chan[k] = CHAN_W'(
                            $signed({pins[k*DIFF_STRIDE + SAMPLE_W-1],
                                     pins[k*DIFF_STRIDE +: SAMPLE_W]})
                          - $signed({pins[k*DIFF_STRIDE + 2*SAMPLE_W-1],
                                     pins[k*DIFF_STRIDE + SAMPLE_W +: SAMPLE_W]}));
                    end
                    st_next.chan[2] = '0;
                    st_next.chan[3] = '0;
                end
                FMT_EXP,
                FMT_EXP_AB: begin
                    for (int k = 0; k < 3; k++) begin
                        st_next.chan[k] = {1'b0,
                            pins[k*EXP_STRIDE + MANT_W +: EXP_W],
                            pins[k*EXP_STRIDE +: MANT_W]};
                    end
                    st_next.chan[3] = '0;
                    if (fmt == FMT_EXP_AB) begin
                        st_next.ab_sel = pins[AB_SEL_BIT];
                    end
                end
                default: begin
                    st_next.chan   = '0;
                    st_next.strobe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg           <= '0;
            st_reg.mem       <= {NUM_LOC{REG_RESET}};
            st_reg.page      <= PAGE_RESET;
            st_reg.wr_n_d    <= 1'b1;
            st_reg.valid_n_d <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cdata_out   = st_reg.cdata;
    assign cdata_oe    = st_reg.cdata_oe;
    assign pdata_out   = st_reg.pdata;
    assign pdata_oe    = st_reg.pdata_oe;
    assign chan_word_0 = st_reg.chan[0];
    assign chan_word_1 = st_reg.chan[1];
    assign chan_word_2 = st_reg.chan[2];
    assign chan_word_3 = st_reg.chan[3];
    assign chan_ab_sel = st_reg.ab_sel;
    assign chan_strobe = st_reg.strobe;
    assign page_out    = st_reg.page;
endmodule

// file: tb/ddcp_monitor.sv
`timescale 1ns/1ps
module ddcp_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce_n,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic [4:0]  addr,
    input wire logic [7:0]  cdata_in,
    input wire logic        cdata_oe,
    input wire logic        addr4_mode,
    input wire logic        wide_mode,
    input wire logic [23:0] pdata_out,
    input wire logic        pdata_oe,
    input wire logic [2:0]  input_format,
    input wire logic [13:0] sample_port_a,
    input wire logic        sample_valid_n,
    input wire logic [15:0] chan_word_0,
    input wire logic        chan_strobe,
    input wire logic [7:0]  page_out
);
    wire logic rd_cond = !ce_n && !rd_n && wr_n;
    wire logic out_pg  = page_out[1:0] == 2'h3;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_bus_drive_cond: assert property (cdata_oe |-> $past(rd_cond))
        else $error("bus driven outside read");
    a_read_answer: assert property (rd_cond |=> cdata_oe)
        else $error("read not answered");
    a_ce_gate: assert property ($rose(wr_n) && ce_n |=> $stable(page_out))
        else $error("write taken without enable");
    a_page_write: assert property ($rose(wr_n) && !ce_n && !addr4_mode && addr == 5'h1F
        |=> page_out == $past(cdata_in)) else $error("page write lost");
    a_wide_gate: assert property (pdata_oe |-> $past(rd_cond) && $past(wide_mode))
        else $error("wide bus driven wrongly");
    a_wide_idle: assert property (pdata_oe && !$past(addr4_mode) && !$past(out_pg)
        |-> pdata_out == 24'hFF_FFFF) else $error("wide bus not all ones");
    a_strobe_valid: assert property (chan_strobe |-> $past(sample_valid_n, 2) == 1'b0)
        else $error("update while invalid");
    a_quad_map: assert property (chan_strobe && $past(input_format) == 3'h0
        |-> chan_word_0 == 16'($signed($past(sample_port_a, 2)))) else $error("quad word");
endmodule
bind ddcp_top ddcp_monitor i_mon (.*);

// file: tb/ddcp_host_model.sv
`timescale 1ns/1ps
module ddcp_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] cdata_out,
    input  wire logic       cdata_oe,
    output logic            ce_n = 1'b1,
    output logic            rd_n = 1'b1,
    output logic            wr_n = 1'b1,
    output logic      [4:0] addr = 5'h00,
    output logic      [7:0] cdata_in
);
    logic [7:0] drv = 8'h00;
    // Released lines carry the inverse of the last value
    assign cdata_in = cdata_oe ? cdata_out : drv;
    task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic c);
        @(posedge clk);
        {ce_n, wr_n, addr, drv} <= {c, 1'b0, a, v};
        @(posedge clk);
        wr_n <= 1'b1;
        @(posedge clk);
        {ce_n, addr, drv} <= {1'b1, ~a, ~v};
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge clk);
        {ce_n, rd_n, addr} <= {2'b00, a};
        @(posedge clk);
        @(posedge clk);
        v = cdata_in;
        {ce_n, rd_n, addr} <= {2'b11, ~a};
    endtask
endmodule

// file: tb/test_ddc_control_port_and_input_capture.sv
`timescale 1ns/1ps
module test_ddc_control_port_and_input_capture;
    import ddcp_pkg::*;
    typedef struct packed {logic [2:0] fmt; logic [55:0] pins; logic [64:0] exp;} ddcp_row_s;
    localparam ddcp_row_s ROWS [5] = '{
        '{3'h0, {14'h3FFF, 14'h0005, 14'h1FFF, 14'h2001}, {1'b0, 64'hFFFF_0005_1FFF_E001}},
        '{3'h1, {8'h00, 16'hC003, 16'hB002, 16'hA001}, {1'b0, 64'h0000_C003_B002_A001}},
        '{3'h2, {14'h0001, 14'h0003, 14'h3FFE, 14'h0005}, {1'b0, 64'h0000_0000_0002_0007}},
        '{3'h3, {11'h000, 15'h5FFF, 15'h1234, 15'h7ABC}, {1'b0, 64'h0000_5FFF_1234_7ABC}},
        '{3'h4, {10'h000, 1'b1, 15'h0001, 15'h2002, 15'h4003}, {1'b1, 64'h0000_0001_2002_4003}}};
    logic        clk = 1'b0, rst = 1'b1, addr4_mode = 1'b0, wide_mode = 1'b0;
    logic        sample_valid_n = 1'b0, ce_n, rd_n, wr_n, cdata_oe, pdata_oe;
    logic        chan_ab_sel, chan_strobe;
    logic [2:0]  input_format = 3'h0;
    logic [4:0]  addr;
    logic [7:0]  cdata_in, cdata_out, page_out, d;
    logic [15:0] chan_word_0, chan_word_1, chan_word_2, chan_word_3;
    logic [23:0] pdata_out, out_word = 24'h12_3456;
    logic [55:0] pins = 56'h0;
    int          miscompares = 0, n_checks = 0;
    always #5 clk = ~clk;
    ddcp_top i_dut (.clk, .rst, .ce_n, .rd_n, .wr_n, .addr, .cdata_in, .cdata_out, .cdata_oe,
        .addr4_mode, .wide_mode, .out_word, .pdata_out, .pdata_oe, .input_format,
        .sample_port_a(pins[13:0]), .sample_port_b(pins[27:14]), .sample_port_c(pins[41:28]),
        .sample_port_d(pins[55:42]), .sample_valid_n, .chan_word_0, .chan_word_1,
        .chan_word_2, .chan_word_3, .chan_ab_sel, .chan_strobe, .page_out);
    ddcp_host_model i_host (.clk, .cdata_out, .cdata_oe, .ce_n, .rd_n, .wr_n, .addr, .cdata_in);
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] want);
        n_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("page", page_out, 8'h00);
        for (int i = 0; i < 5; i++) begin
            {input_format, pins} <= {ROWS[i].fmt, ROWS[i].pins};
            repeat (3) @(posedge clk);
            chk("strobe", chan_strobe, 1'b1);
            chk("words", {chan_word_3, chan_word_2, chan_word_1, chan_word_0}, ROWS[i].exp[63:0]);
            chk("ab", chan_ab_sel, ROWS[i].exp[64]);
        end
        // Format stays put so the last update before the hold keeps its grouping
        {sample_valid_n, pins} <= {1'b1, 56'h0};
        repeat (3) @(posedge clk);
        chk("held", {chan_strobe, chan_word_0}, 17'h0_4003);
        sample_valid_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("resume", chan_word_0, 16'h0000);
        {input_format, pins} <= {3'h5, {4{14'h1555}}};
        repeat (3) @(posedge clk);
        chk("reserved", {chan_word_3, chan_word_2, chan_word_1, chan_word_0}, 64'h0);
        chk("reserved strobe", chan_strobe, 1'b0);
        i_host.wr(5'h03, 8'h5A, 1'b0);
        i_host.wr(5'h1F, 8'h02, 1'b0);
        i_host.wr(5'h03, 8'hC3, 1'b0);
        i_host.wr(5'h1F, 8'hEE, 1'b1);
        i_host.rd(5'h1F, d);
        chk("page", d, 8'h02);
        i_host.rd(5'h03, d);
        chk("page 2", d, 8'hC3);
        wide_mode <= 1'b1;
        i_host.wr(5'h1F, 8'h00, 1'b0);
        i_host.rd(5'h03, d);
        chk("page 0", d, 8'h5A);
        chk("idle", pdata_out, 24'hFF_FFFF);
        addr4_mode <= 1'b1;
        i_host.rd(5'h13, d);
        chk("addr4", d, 8'h5A);
        i_host.wr(5'h0F, 8'h06, 1'b0);
        i_host.rd(5'h02, d);
        chk("out page", pdata_out, 24'h12_3456);
        repeat (2) @(posedge clk);
        chk("release", {cdata_oe, pdata_oe}, 2'b00);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("reset page", page_out, 8'h00);
        chk("reset oe", {cdata_oe, pdata_oe}, 2'b00);
        report_and_stop();
    end
endmodule
